// ===== hw/ulm_status_ctrl.sv
// UART channel status, modem control, scratch, feature and RS-485 logic
// Operation
// - Character done with full receive FIFO sets overrun, no push, FIFO untouched.
// - Data-ready is 1 while receive FIFO holds a character, 0 otherwise, resets 0.
// - Outside loopback, status bits 7..4 are inverted carrier, bell, set-ready, clear-to-send pins.
// - In loopback, status bits mirror loop_out_two, loop_out_one, terminal-ready, request-to-send.
// - Auto flow, select 0: clear_to_send_n high stops transmitter after current character.
// - Auto flow, select 1: set_ready_in_n gates transmitter the same way.
// - Carrier, set-ready, clear-to-send changes set flags; flags request modem interrupt when enabled.
// - Ring change flag sets only on bell_signal_n rising, then requests modem interrupt.
// - Write bits 7..4 delay RS-485 turnaround by 0 to 15 bit times after last stop.
// - Turnaround delay bits accept writes only while enhanced enable is set.
// - Transmitter-disable 1 halts the shift register; 0 releases queued bytes; resets 0.
// - Receiver-disable 1 halts receiving; FIFO stays readable; resets 0.
// - Scratch is 8-bit read/write, loads 0xff on reset.
// - Feature bits 7..6 pick table; tables A-C flow one trigger level above/below.
// - Auto RS-485: request-to-send falls after last stop bit plus programmed delay.
// - Auto RS-485: request-to-send rises when a byte is loaded, before start bit.
// - Transmit interrupt on holding empty, or on shift register empty with RS-485.
// - Feature hysteresis bits act only when trigger table D is selected.
// - Modem control write bits 7..2 change only while enhanced enable is 1.
`timescale 1ns/1ps

module ulm_status_ctrl #(
  parameter int unsigned FIFO_CNT_W = 7
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  // Host register port
  input  wire logic                  reg_cs,
  input  wire logic                  reg_rd,
  input  wire logic                  reg_wr,
  input  wire logic [3:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  // Control bits held by other registers of the channel
  input  wire logic                  loop_en,
  input  wire logic                  loop_out_two,
  input  wire logic                  loop_out_one,
  input  wire logic                  term_ready_ctl,
  input  wire logic                  req_send_ctl,
  input  wire logic                  flow_pin_sel,
  input  wire logic                  modem_irq_en,
  input  wire logic                  enhanced_en,
  input  wire logic                  auto_cts_en,
  input  wire logic                  auto_rts_en,
  // Modem pins
  input  wire logic                  carrier_detect_n,
  input  wire logic                  bell_signal_n,
  input  wire logic                  set_ready_in_n,
  input  wire logic                  clear_to_send_n,
  output logic                       req_to_send_n,
  output logic                       term_ready_n,
  // Receiver side
  input  wire logic                  rx_char_done,
  input  wire logic                  rx_fifo_full,
  input  wire logic [FIFO_CNT_W-1:0] rx_fifo_count,
  input  wire logic [FIFO_CNT_W-1:0] rx_trig_level,
  input  wire logic [FIFO_CNT_W-1:0] rx_level_above,
  input  wire logic [FIFO_CNT_W-1:0] rx_level_below,
  input  wire logic [3:0]            rx_err_flags,
  output logic                       rx_push,
  output logic                       rx_enable,
  // Transmitter side
  input  wire logic                  tx_load,
  input  wire logic                  tx_hold_empty,
  input  wire logic                  tx_shift_busy,
  input  wire logic                  tx_char_end,
  input  wire logic                  bit_tick,
  output logic                       tx_go,
  output logic                       tx_irq,
  output logic                       modem_irq
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0]            pin_s1;
    logic [3:0]            pin_s2;
    logic [3:0]            pin_s3;
    logic [3:0]            pin_f;
    logic [3:0]            stat_prev;
    logic [3:0]            delta;
    logic                  overrun;
    logic [7:0]            scratch;
    logic [7:0]            feature;
    logic [3:0]            delay_bits;
    logic                  tx_dis;
    logic                  rx_dis;
    ulm_pkg::ulm_rs_state_t rs_state;
    logic [3:0]            rs_cnt;
    logic                  flow_hold;
    logic                  hold_empty_d;
    logic                  tsr_empty_d;
    logic [7:0]            rdata;
    logic                  rx_push;
    logic                  tx_go;
    logic                  rx_enable;
    logic                  rts_n;
    logic                  dtr_n;
    logic                  modem_irq;
    logic                  tx_irq;
  } ulm_state_t;

  ulm_state_t st;
  ulm_state_t next_st;

  // ----------------------------------------------------------------------------
  // Combinational helpers
  // ----------------------------------------------------------------------------
  logic       rd_lsr;
  logic       rd_msr;
  logic       wr_msr;
  logic       wr_spr;
  logic       wr_fc;
  logic [3:0] stat_now;
  logic [3:0] events;
  logic [7:0] line_stat;
  logic [7:0] hyst_up;
  logic [7:0] hyst_dn;
  logic [7:0] upper_lvl;
  logic [7:0] lower_lvl;
  logic [5:0] hyst;
  logic       table_d;
  logic       tsr_empty;
  logic       last_char;
  logic       flow_stop;

  always_comb begin
    rd_lsr = reg_cs && reg_rd && (reg_addr == ulm_pkg::OFS_LINE_STATUS);
    rd_msr = reg_cs && reg_rd && (reg_addr == ulm_pkg::OFS_MODEM_STAT);
    wr_msr = reg_cs && reg_wr && (reg_addr == ulm_pkg::OFS_MODEM_STAT);
    wr_spr = reg_cs && reg_wr && (reg_addr == ulm_pkg::OFS_SCRATCH);
    wr_fc  = reg_cs && reg_wr && (reg_addr == ulm_pkg::OFS_FEATURE);

    // Live modem status, upper nibble
    if (loop_en) begin
      stat_now = {loop_out_two, loop_out_one, term_ready_ctl, req_send_ctl};
    end else begin
      stat_now = ~st.pin_f;
    end

    // Change events; ring counts only the pin rising
    events                  = stat_now ^ st.stat_prev;
    events[ulm_pkg::PIN_RI] = st.stat_prev[ulm_pkg::PIN_RI] && !stat_now[ulm_pkg::PIN_RI];

    tsr_empty = tx_hold_empty && !tx_shift_busy;
    line_stat = {rx_err_flags[3], tsr_empty, tx_hold_empty, rx_err_flags[2:0],
                 st.overrun, (rx_fifo_count != '0)};

    // Flow thresholds
    table_d = (st.feature[ulm_pkg::FC_TABLE_LSB +: 2] == ulm_pkg::TABLE_D);
    hyst    = ulm_pkg::ulm_hyst(st.feature[ulm_pkg::FC_HYST_LSB +: 4]);
    hyst_up = 8'(rx_trig_level) + {2'h0, hyst};
    hyst_dn = (8'(rx_trig_level) > {2'h0, hyst}) ? (8'(rx_trig_level) - {2'h0, hyst}) : 8'h00;
    if (table_d && (hyst != 6'h00)) begin
      upper_lvl = hyst_up;
      lower_lvl = hyst_dn;
    end else begin
      upper_lvl = 8'(rx_level_above);
      lower_lvl = 8'(rx_level_below);
    end

    last_char = tx_char_end && tx_hold_empty;
    if (flow_pin_sel) begin
      flow_stop = auto_cts_en && st.pin_f[ulm_pkg::PIN_DSR];
    end else begin
      flow_stop = auto_cts_en && st.pin_f[ulm_pkg::PIN_CTS];
    end
  end

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    next_st = st;

    // Three-stage pin capture; a level counts once stages two and three agree
    next_st.pin_s1 = {carrier_detect_n, bell_signal_n, set_ready_in_n, clear_to_send_n};
    next_st.pin_s2 = st.pin_s1;
    next_st.pin_s3 = st.pin_s2;
    for (int i = 0; i < 4; i++) begin
      if (st.pin_s2[i] == st.pin_s3[i]) begin
        next_st.pin_f[i] = st.pin_s3[i];
      end
    end

    // Change flags: a new event wins over the clearing read
    next_st.stat_prev = stat_now;
    next_st.delta     = (rd_msr ? 4'h0 : st.delta) | events;
    next_st.modem_irq = modem_irq_en && (next_st.delta != 4'h0);

    // Receive path
    next_st.rx_push   = 1'b0;
    next_st.overrun   = rd_lsr ? 1'b0 : st.overrun;
    if (rx_char_done && !st.rx_dis) begin
      if (rx_fifo_full) begin
        next_st.overrun = 1'b1;
      end else begin
        next_st.rx_push = 1'b1;
      end
    end

    // Register writes
    if (wr_spr) begin
      next_st.scratch = reg_wdata;
    end
    if (wr_fc) begin
      next_st.feature = reg_wdata;
    end
    if (wr_msr && enhanced_en) begin
      next_st.delay_bits = reg_wdata[ulm_pkg::MCW_DELAY_LSB +: 4];
      next_st.tx_dis     = reg_wdata[ulm_pkg::MCW_TX_DIS];
      next_st.rx_dis     = reg_wdata[ulm_pkg::MCW_RX_DIS];
    end
    next_st.rx_enable = !next_st.rx_dis;

    // Read data, registered; unmapped offsets read zero
    next_st.rdata = st.rdata;
    if (reg_cs && reg_rd) begin
      case (reg_addr)
        ulm_pkg::OFS_LINE_STATUS: next_st.rdata = line_stat;
        ulm_pkg::OFS_MODEM_STAT:  next_st.rdata = {stat_now, st.delta};
        ulm_pkg::OFS_SCRATCH:     next_st.rdata = st.scratch;
        ulm_pkg::OFS_FEATURE:     next_st.rdata = st.feature;
        default:                  next_st.rdata = 8'h00;
      endcase
    end

    // Transmit permission, registered every cycle from transmitter-disable and flow stop
    next_st.tx_go = !st.tx_dis && !flow_stop;

    // Transmit interrupt source
    next_st.hold_empty_d = tx_hold_empty;
    next_st.tsr_empty_d  = tsr_empty;
    if (st.feature[ulm_pkg::FC_RS485]) begin
      next_st.tx_irq = tsr_empty && !st.tsr_empty_d;
    end else begin
      next_st.tx_irq = tx_hold_empty && !st.hold_empty_d;
    end

    // Receive flow hold for automatic request-to-send
    if (8'(rx_fifo_count) >= upper_lvl) begin
      next_st.flow_hold = 1'b1;
    end else if (8'(rx_fifo_count) < lower_lvl) begin
      next_st.flow_hold = 1'b0;
    end

    // RS-485 direction sequencer
    case (st.rs_state)
      ulm_pkg::RS_IDLE: begin
        if (tx_load) begin
          next_st.rs_state = ulm_pkg::RS_DRIVE;
        end
      end
      ulm_pkg::RS_DRIVE: begin
        if (last_char && !tx_load) begin
          next_st.rs_cnt = 4'h0;
          if (st.delay_bits == 4'h0) begin
            next_st.rs_state = ulm_pkg::RS_IDLE;
          end else begin
            next_st.rs_state = ulm_pkg::RS_HOLD;
          end
        end
      end
      ulm_pkg::RS_HOLD: begin
        if (tx_load) begin
          next_st.rs_state = ulm_pkg::RS_DRIVE;
        end else if (bit_tick) begin
          next_st.rs_cnt = st.rs_cnt + 4'h1;
          if ((st.rs_cnt + 4'h1) >= st.delay_bits) begin
            next_st.rs_state = ulm_pkg::RS_IDLE;
          end
        end
      end
      default: begin
        next_st.rs_state = ulm_pkg::RS_IDLE;
      end
    endcase

    // Request-to-send and terminal-ready pins
    if (st.feature[ulm_pkg::FC_RS485]) begin
      next_st.rts_n = (next_st.rs_state != ulm_pkg::RS_IDLE);
    end else begin
      next_st.rts_n = !req_send_ctl || (auto_rts_en && !flow_pin_sel && next_st.flow_hold);
    end
    next_st.dtr_n = !term_ready_ctl || (auto_rts_en && flow_pin_sel && next_st.flow_hold);
  end

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st            <= '0;
      st.pin_s1     <= ulm_pkg::PIN_IDLE;
      st.pin_s2     <= ulm_pkg::PIN_IDLE;
      st.pin_s3     <= ulm_pkg::PIN_IDLE;
      st.pin_f      <= ulm_pkg::PIN_IDLE;
      st.scratch    <= ulm_pkg::SCRATCH_RESET;
      st.feature    <= ulm_pkg::FEATURE_RESET;
      st.delay_bits <= ulm_pkg::DELAY_RESET;
      st.tx_dis     <= 1'b0;
      st.rx_dis     <= 1'b0;
      st.rs_state   <= ulm_pkg::RS_IDLE;
      st.rx_enable  <= 1'b1;
      st.rts_n      <= 1'b1;
      st.dtr_n      <= 1'b1;
      st.hold_empty_d <= 1'b1;
      st.tsr_empty_d  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign reg_rdata     = st.rdata;
  assign req_to_send_n = st.rts_n;
  assign term_ready_n  = st.dtr_n;
  assign rx_push       = st.rx_push;
  assign rx_enable     = st.rx_enable;
  assign tx_go         = st.tx_go;
  assign tx_irq        = st.tx_irq;
  assign modem_irq     = st.modem_irq;

endmodule

// ===== pkg/ulm_pkg.sv
// Constants, types and helpers for the UART line/modem status and RS-485 control block
package ulm_pkg;

  // ----------------------------------------------------------------------------
  // Register offsets on the parallel host port
  // ----------------------------------------------------------------------------
  localparam int unsigned REG_ADDR_W      = 4;
  localparam logic [3:0]  OFS_LINE_STATUS = 4'h5;
  localparam logic [3:0]  OFS_MODEM_STAT  = 4'h6;
  localparam logic [3:0]  OFS_SCRATCH     = 4'h7;
  localparam logic [3:0]  OFS_FEATURE     = 4'h8;

  // ----------------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------------
  localparam logic [7:0]  SCRATCH_RESET   = 8'hff;
  localparam logic [7:0]  FEATURE_RESET   = 8'h00;
  localparam logic [3:0]  DELAY_RESET     = 4'h0;
  localparam logic [3:0]  PIN_IDLE        = 4'hf;

  // ----------------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------------
  // Write-only modem control: delay in [7:4], tx disable [3], rx disable [2]
  localparam int unsigned MCW_DELAY_LSB   = 4;
  localparam int unsigned MCW_TX_DIS      = 3;
  localparam int unsigned MCW_RX_DIS      = 2;
  // Feature control: table [7:6], RS-485 enable [5], hysteresis [3:0]
  localparam int unsigned FC_TABLE_LSB    = 6;
  localparam int unsigned FC_RS485        = 5;
  localparam int unsigned FC_HYST_LSB     = 0;
  localparam logic [1:0]  TABLE_D         = 2'h3;
  // Pin vector order {carrier, bell, set_ready, clear_to_send}
  localparam int unsigned PIN_CD          = 3;
  localparam int unsigned PIN_RI          = 2;
  localparam int unsigned PIN_DSR         = 1;
  localparam int unsigned PIN_CTS         = 0;

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RS_IDLE  = 2'b00,
    RS_DRIVE = 2'b01,
    RS_HOLD  = 2'b10
  } ulm_rs_state_t;

  // Hysteresis in characters for trigger table D
  function automatic logic [5:0] ulm_hyst(input logic [3:0] code);
    case (code)
      4'h0:    ulm_hyst = 6'h00;
      4'h1:    ulm_hyst = 6'h04;
      4'h2:    ulm_hyst = 6'h06;
      4'h3:    ulm_hyst = 6'h08;
      4'h4:    ulm_hyst = 6'h08;
      4'h5:    ulm_hyst = 6'h10;
      4'h6:    ulm_hyst = 6'h18;
      4'h7:    ulm_hyst = 6'h20;
      4'h8:    ulm_hyst = 6'h28;
      4'h9:    ulm_hyst = 6'h2c;
      4'ha:    ulm_hyst = 6'h30;
      4'hb:    ulm_hyst = 6'h34;
      4'hc:    ulm_hyst = 6'h0c;
      4'hd:    ulm_hyst = 6'h14;
      4'he:    ulm_hyst = 6'h1c;
      default: ulm_hyst = 6'h24;
    endcase
  endfunction

endpackage

// ===== verif/tb.sv
// Bench for the UART status block
`timescale 1ns/1ps
module tb;
  logic       sys_clk = 1'b0, reset_n = 1'b0, reg_cs = 1'b0, reg_rd = 1'b0, reg_wr = 1'b0;
  logic [3:0] reg_addr = 4'h0, pin_req = 4'hf;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic       loop_en = 1'b0, loop_out_two = 1'b0, loop_out_one = 1'b0, term_ready_ctl = 1'b0;
  logic       req_send_ctl = 1'b0, flow_pin_sel = 1'b0, modem_irq_en = 1'b1, enhanced_en = 1'b1;
  logic       auto_cts_en = 1'b0, auto_rts_en = 1'b0, rx_char_done = 1'b0, rx_fifo_full = 1'b0;
  logic       tx_load = 1'b0, tx_hold_empty = 1'b1, tx_shift_busy = 1'b0, tx_char_end = 1'b0, bit_tick = 1'b0;
  logic [6:0] rx_fifo_count = 7'h00, rx_level_above = 7'h08, rx_level_below = 7'h04;
  logic       carrier_detect_n, bell_signal_n, set_ready_in_n, clear_to_send_n;
  logic       req_to_send_n, term_ready_n, rx_push, rx_enable, tx_go, tx_irq, modem_irq;
  int         error_cnt = 0, checked = 0, irq_cnt = 0;

  ulm_status_ctrl dut_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_cs(reg_cs), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .loop_en(loop_en),
    .loop_out_two(loop_out_two), .loop_out_one(loop_out_one), .term_ready_ctl(term_ready_ctl),
    .req_send_ctl(req_send_ctl), .flow_pin_sel(flow_pin_sel), .modem_irq_en(modem_irq_en),
    .enhanced_en(enhanced_en), .auto_cts_en(auto_cts_en), .auto_rts_en(auto_rts_en),
    .carrier_detect_n(carrier_detect_n), .bell_signal_n(bell_signal_n), .set_ready_in_n(set_ready_in_n),
    .clear_to_send_n(clear_to_send_n), .req_to_send_n(req_to_send_n), .term_ready_n(term_ready_n),
    .rx_char_done(rx_char_done), .rx_fifo_full(rx_fifo_full), .rx_fifo_count(rx_fifo_count),
    .rx_trig_level(7'h10), .rx_level_above(rx_level_above), .rx_level_below(rx_level_below),
    .rx_err_flags(4'h0), .rx_push(rx_push), .rx_enable(rx_enable), .tx_load(tx_load),
    .tx_hold_empty(tx_hold_empty), .tx_shift_busy(tx_shift_busy), .tx_char_end(tx_char_end),
    .bit_tick(bit_tick), .tx_go(tx_go), .tx_irq(tx_irq), .modem_irq(modem_irq)
  );
  ulm_modem_model modem_u (
    .pin_req(pin_req), .sys_clk(sys_clk), .carrier_detect_n(carrier_detect_n),
    .bell_signal_n(bell_signal_n), .set_ready_in_n(set_ready_in_n), .clear_to_send_n(clear_to_send_n)
  );

  always #2.5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (tx_irq === 1'b1) irq_cnt++;

  // ----------------------------------------------------------------------------
  // Access and check tasks
  // ----------------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task summarize();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task chk(input logic [7:0] got, exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask
  task wr(input logic [3:0] a, logic [7:0] d);
    reg_cs = 1'b1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    cyc(1);
    reg_cs = 1'b0;
    reg_wr = 1'b0;
    cyc(1);
  endtask
  task rd(input logic [3:0] a, logic [7:0] e, m);
    reg_cs = 1'b1;
    reg_rd = 1'b1;
    reg_addr = a;
    cyc(1);
    reg_cs = 1'b0;
    reg_rd = 1'b0;
    chk(reg_rdata & m, e);
    cyc(1);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task wait_go(input logic v);
    int n;
    n = 0;
    while (tx_go !== v && n < 20) begin
      cyc(1);
      n++;
    end
    chk1(tx_go, v);
    if (tx_go !== v) summarize();
  endtask
  task lvl(input logic [6:0] c, logic e);
    rx_fifo_count = c;
    cyc(3);
    chk1(req_to_send_n, e);
  endtask
  // RS-485 frame: load, character end, d turnaround ticks
  task rs_frame(input logic [7:0] w, int d);
    wr(ulm_pkg::OFS_MODEM_STAT, w);
    irq_cnt = 0;
    tx_hold_empty = 1'b0;
    pulse(tx_load);
    tx_shift_busy = 1'b1;
    tx_hold_empty = 1'b1;
    chk1(req_to_send_n, 1'b1);
    cyc(3);
    tx_shift_busy = 1'b0;
    pulse(tx_char_end);
    repeat (d) begin
      chk1(req_to_send_n, 1'b1);
      pulse(bit_tick);
      cyc(1);
    end
    chk1(req_to_send_n, 1'b0);
    cyc(2);
    chk(irq_cnt[7:0], 8'h01);
  endtask

  initial begin
    cyc(20000);
    error_cnt++;
    $display("Error at %0t ns: run timed out", $time);
    summarize();
  end

  initial begin
    cyc(20);
    reset_n = 1'b1;
    rd(ulm_pkg::OFS_SCRATCH, 8'hff, 8'hff);
    rd(ulm_pkg::OFS_LINE_STATUS, 8'h00, 8'h03);
    rd(ulm_pkg::OFS_MODEM_STAT, 8'h00, 8'h0f);
    chk1(rx_enable, 1'b1);
    chk1(tx_go, 1'b1);
    wr(ulm_pkg::OFS_SCRATCH, 8'ha5);
    rd(ulm_pkg::OFS_SCRATCH, 8'ha5, 8'hff);
    $display("Test reset_scratch done");
    pulse(rx_char_done);
    chk1(rx_push, 1'b1);
    rx_fifo_full = 1'b1;
    pulse(rx_char_done);
    chk1(rx_push, 1'b0);
    rx_fifo_full = 1'b0;
    rx_fifo_count = 7'h03;
    rd(ulm_pkg::OFS_LINE_STATUS, 8'h03, 8'h03);
    rd(ulm_pkg::OFS_LINE_STATUS, 8'h01, 8'h03);
    $display("Test receive done");
    pin_req = 4'b0101;
    cyc(8);
    chk1(modem_irq, 1'b1);
    rd(ulm_pkg::OFS_MODEM_STAT, 8'haa, 8'hff);
    rd(ulm_pkg::OFS_MODEM_STAT, 8'ha0, 8'hff);
    chk1(modem_irq, 1'b0);
    pin_req[2] = 1'b0;
    cyc(8);
    rd(ulm_pkg::OFS_MODEM_STAT, 8'he0, 8'hff);
    pin_req[2] = 1'b1;
    cyc(8);
    rd(ulm_pkg::OFS_MODEM_STAT, 8'ha4, 8'hff);
    modem_irq_en = 1'b0;
    pin_req[0] = 1'b0;
    cyc(8);
    chk1(modem_irq, 1'b0);
    rd(ulm_pkg::OFS_MODEM_STAT, 8'hb1, 8'hff);
    loop_en = 1'b1;
    for (int i = 0; i < 16; i++) begin
      {loop_out_two, loop_out_one, term_ready_ctl, req_send_ctl} = i[3:0];
      rd(ulm_pkg::OFS_MODEM_STAT, {i[3:0], 4'h0}, 8'hf0);
    end
    loop_en = 1'b0;
    rd(ulm_pkg::OFS_MODEM_STAT, 8'hb0, 8'hf0);
    $display("Test modem_status done");
    auto_cts_en = 1'b1;
    pin_req[0] = 1'b1;
    wait_go(1'b0);
    cyc(3);
    pin_req[0] = 1'b0;
    wait_go(1'b1);
    flow_pin_sel = 1'b1;
    pin_req[1] = 1'b1;
    wait_go(1'b0);
    pin_req = 4'b0100;
    wait_go(1'b1);
    auto_cts_en = 1'b0;
    enhanced_en = 1'b0;
    wr(ulm_pkg::OFS_MODEM_STAT, 8'h08);
    chk1(tx_go, 1'b1);
    enhanced_en = 1'b1;
    wr(ulm_pkg::OFS_MODEM_STAT, 8'h08);
    wait_go(1'b0);
    wr(ulm_pkg::OFS_MODEM_STAT, 8'h04);
    wait_go(1'b1);
    chk1(rx_enable, 1'b0);
    pulse(rx_char_done);
    chk1(rx_push, 1'b0);
    rd(ulm_pkg::OFS_LINE_STATUS, 8'h01, 8'h01);
    $display("Test flow_disable done");
    flow_pin_sel = 1'b0;
    req_send_ctl = 1'b1;
    auto_rts_en = 1'b1;
    wr(ulm_pkg::OFS_FEATURE, 8'h01);
    lvl(7'd7, 1'b0);
    lvl(7'd8, 1'b1);
    lvl(7'd4, 1'b1);
    lvl(7'd3, 1'b0);
    wr(ulm_pkg::OFS_FEATURE, 8'hc1);
    lvl(7'd8, 1'b0);
    lvl(7'd20, 1'b1);
    lvl(7'd12, 1'b1);
    lvl(7'd11, 1'b0);
    flow_pin_sel = 1'b1;
    lvl(7'd20, 1'b0);
    chk1(term_ready_n, 1'b1);
    lvl(7'd11, 1'b0);
    chk1(term_ready_n, 1'b0);
    auto_rts_en = 1'b0;
    $display("Test auto_rts done");
    wr(ulm_pkg::OFS_FEATURE, 8'h20);
    rs_frame(8'h00, 0);
    rs_frame(8'hf0, 15);
    enhanced_en = 1'b0;
    rs_frame(8'h20, 15);
    enhanced_en = 1'b1;
    wr(ulm_pkg::OFS_FEATURE, 8'h00);
    irq_cnt = 0;
    tx_hold_empty = 1'b0;
    cyc(2);
    tx_hold_empty = 1'b1;
    cyc(3);
    chk(irq_cnt[7:0], 8'h01);
    $display("Test rs485 done");
    summarize();
  end
endmodule

// ===== verif/ulm_modem_model.sv
// Modem partner model driving the four status pins
`timescale 1ns/1ps
module ulm_modem_model (
  input  wire logic [3:0] pin_req,
  input  wire logic       sys_clk,
  output logic            carrier_detect_n,
  output logic            bell_signal_n,
  output logic            set_ready_in_n,
  output logic            clear_to_send_n
);
  // Pins idle high and move off the sampling edge
  initial {carrier_detect_n, bell_signal_n, set_ready_in_n, clear_to_send_n} = 4'hf;
  always @(negedge sys_clk) begin
    #1 {carrier_detect_n, bell_signal_n, set_ready_in_n, clear_to_send_n} = pin_req;
  end
endmodule

// ===== verif/ulm_status_ctrl_sva.sv
// Assertions for the UART status block
`timescale 1ns/1ps
module ulm_sva #(
  parameter int unsigned FIFO_CNT_W = 7
) (
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic       reg_cs,
  input wire logic       reg_rd,
  input wire logic       reg_wr,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       loop_en,
  input wire logic       loop_out_two,
  input wire logic       loop_out_one,
  input wire logic       term_ready_ctl,
  input wire logic       req_send_ctl,
  input wire logic       flow_pin_sel,
  input wire logic       modem_irq_en,
  input wire logic       auto_cts_en,
  input wire logic       carrier_detect_n,
  input wire logic       bell_signal_n,
  input wire logic       set_ready_in_n,
  input wire logic       clear_to_send_n,
  input wire logic       req_to_send_n,
  input wire logic       rx_char_done,
  input wire logic       rx_fifo_full,
  input wire logic       rx_push,
  input wire logic       rx_enable,
  input wire logic       tx_load,
  input wire logic       tx_hold_empty,
  input wire logic       tx_shift_busy,
  input wire logic       tx_char_end,
  input wire logic       bit_tick,
  input wire logic       tx_go,
  input wire logic       tx_irq,
  input wire logic       modem_irq
);
  logic [3:0] pins, pins_q;
  logic [2:0] age;
  logic       rs_on, rd6;
  logic [7:0] scr;
  assign pins = {carrier_detect_n, bell_signal_n, set_ready_in_n, clear_to_send_n};
  assign rd6  = reg_cs && reg_rd && reg_addr == ulm_pkg::OFS_MODEM_STAT;
  // Shadows of pin stability, RS-485 enable and scratch contents
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pins_q <= ulm_pkg::PIN_IDLE;
      age    <= 3'h0;
      rs_on  <= 1'b0;
      scr    <= ulm_pkg::SCRATCH_RESET;
    end else begin
      pins_q <= pins;
      age    <= (pins != pins_q) ? 3'h0 : age + {2'h0, age != 3'h7};
      if (reg_cs && reg_wr && reg_addr == ulm_pkg::OFS_FEATURE) begin
        rs_on <= reg_wdata[ulm_pkg::FC_RS485];
      end
      if (reg_cs && reg_wr && reg_addr == ulm_pkg::OFS_SCRATCH) begin
        scr <= reg_wdata;
      end
    end
  end
  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  push_ok_a: assert property (rx_char_done && !rx_fifo_full && rx_enable |=> rx_push)
    else $error("character not pushed");
  rx_off_a: assert property (rx_char_done && (rx_fifo_full || !rx_enable) |=> !rx_push)
    else $error("push while full or disabled");
  loop_map_a: assert property (rd6 && loop_en |=>
    reg_rdata[7:4] == $past({loop_out_two, loop_out_one, term_ready_ctl, req_send_ctl}))
    else $error("loopback map wrong");
  pin_stat_a: assert property (rd6 && !loop_en && age == 3'h7 |=> reg_rdata[7:4] == ~$past(pins))
    else $error("pin status wrong");
  irq_gate_a: assert property (!modem_irq_en |=> !modem_irq)
    else $error("modem irq while off");
  cts_stop_a: assert property ((auto_cts_en && !flow_pin_sel && clear_to_send_n && !tx_shift_busy)[*7] |-> !tx_go)
    else $error("flow pin did not stop");
  rts_rise_a: assert property (rs_on && tx_load |=> req_to_send_n)
    else $error("no rise on load");
  rts_fall_a: assert property (rs_on && $past(rs_on, 2) && $fell(req_to_send_n) |->
    $past(tx_char_end) || $past(bit_tick))
    else $error("early direction drop");
  irq_hold_a: assert property (!rs_on && $rose(tx_hold_empty) |-> ##[1:2] tx_irq)
    else $error("no holding-empty irq");
  irq_shift_a: assert property (rs_on && $rose(tx_hold_empty && !tx_shift_busy) |-> ##[1:2] tx_irq)
    else $error("no shift-empty irq");
  scr_rd_a: assert property (reg_cs && reg_rd && reg_addr == ulm_pkg::OFS_SCRATCH |=> reg_rdata == $past(scr))
    else $error("scratch read mismatch");
  cover property (rx_push);
  cover property (rs_on ##1 $fell(req_to_send_n));
  cover property (modem_irq);
endmodule

bind ulm_status_ctrl ulm_sva #(.FIFO_CNT_W(FIFO_CNT_W)) sva_u (
  .sys_clk, .reset_n, .reg_cs, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .loop_en,
  .loop_out_two, .loop_out_one, .term_ready_ctl, .req_send_ctl, .flow_pin_sel, .modem_irq_en,
  .auto_cts_en, .carrier_detect_n, .bell_signal_n, .set_ready_in_n, .clear_to_send_n, .req_to_send_n,
  .rx_char_done, .rx_fifo_full, .rx_push, .rx_enable, .tx_load, .tx_hold_empty, .tx_shift_busy,
  .tx_char_end, .bit_tick, .tx_go, .tx_irq, .modem_irq
);
